/* File: hw/pmp_top.sv */
`timescale 1ns/1ns
`include "pmp_regs.svh"
// Notes on behaviour
// - 4/16-bit bus master only, 8-bit both roles
// - each chip select owns one window region
// - window load/store becomes external read/write
// - graphics controller may drive port as master
// - config bit swaps four pin pairs
// - twenty-three address outputs
// - two chip selects, each with acknowledge
// - split strobes or direction plus enable
// - address waits, per-select data waits
// - control polarity per chip select
// - legacy and four-entry auto-indexed slave port
module pmp_top
(
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rstn_in,
    // configuration
    input  wire logic                    master_mode_in,
    input  wire logic [1:0]              bus_width_in,
    input  wire logic                    mux_mode_in,
    input  wire logic                    alt_pin_map_select_in,
    input  wire logic                    alt_master_en_in,
    input  wire logic [1:0]              addr_wait_in,
    input  wire logic [1:0]              cs_en_in,
    input  wire logic [8:0]              cs1_base_in,
    input  wire logic [8:0]              cs1_mask_in,
    input  wire logic [8:0]              cs2_base_in,
    input  wire logic [8:0]              cs2_mask_in,
    input  wire logic [3:0]              cs1_data_wait_in,
    input  wire logic [3:0]              cs2_data_wait_in,
    input  wire logic [1:0]              strobe_mode_in,
    input  wire logic [1:0]              polarity_in,
    input  wire logic [1:0]              ack_en_in,
    // processor access to the window
    input  wire logic                    cpu_req_in,
    input  wire logic                    cpu_we_in,
    input  wire logic [23:0]             cpu_addr_in,
    input  wire logic [15:0]             cpu_wdata_in,
    output logic                         cpu_hit_out,
    output logic                         cpu_stall_out,
    output logic                         cpu_done_out,
    // graphics alternate master
    input  wire logic                    gfx_req_in,
    input  wire logic                    gfx_we_in,
    input  wire logic [23:0]             gfx_addr_in,
    input  wire logic [15:0]             gfx_wdata_in,
    output logic                         gfx_stall_out,
    output logic                         gfx_done_out,
    // read data for either requester
    output logic [15:0]                  rd_data_out,
    // slave port
    input  wire logic                    slv_enhanced_in,
    input  wire logic                    slv_addr_mode_in,
    input  wire logic                    slv_cs_in,
    input  wire logic                    slv_rd_in,
    input  wire logic                    slv_wr_in,
    input  wire logic [1:0]              slv_addr_in,
    input  wire logic                    buf_load_in,
    input  wire logic [1:0]              buf_load_idx_in,
    input  wire logic [7:0]              buf_load_data_in,
    output logic [31:0]                  buf_rx_out,
    output logic                         slv_rx_out,
    output logic [1:0]                   slv_ptr_out,
    // external bus pins
    output logic [23:0]                  pad_map_out,
    output logic                         cs1_pin_out,
    output logic                         strobe_rd_out,
    output logic                         strobe_wr_out,
    output logic                         ale_out,
    output logic [15:0]                  data_out,
    output logic                         data_oe_out,
    input  wire logic [15:0]             data_in,
    input  wire logic [1:0]              ack_in
);

    function automatic logic region_hit(input logic [23:0] addr, input logic [8:0] base,
                                        input logic [8:0] mask, input logic en);
        region_hit = en & ((addr[23:`PMP_PAGE_LSB] & mask) == (base & mask));
    endfunction

    function automatic logic [15:0] width_mask(input logic [1:0] bw, input logic master);
        if (!master)
            width_mask = `PMP_MASK_8;
        else if (bw == `PMP_BW_16)
            width_mask = `PMP_MASK_16;
        else if (bw == `PMP_BW_4)
            width_mask = `PMP_MASK_4;
        else
            width_mask = `PMP_MASK_8;
    endfunction

    function automatic logic [23:0] swap_pins(input logic [23:0] lg);
        logic [23:0] p;
        p     = lg;
        p[23] = lg[22];
        p[22] = lg[23];
        p[5]  = lg[18];
        p[18] = lg[5];
        p[4]  = lg[20];
        p[20] = lg[4];
        p[3]  = lg[21];
        p[21] = lg[3];
        swap_pins = p;
    endfunction

    // reset release
    logic                      rst_meta_ff;
    logic                      rst_sync_ff;
    wire                       rstn = rst_sync_ff;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // master state
    pmp_pkg::pmp_state_t       state_ff;
    pmp_pkg::pmp_state_t       nxt_state;
    logic [3:0]                cnt_ff;
    logic [3:0]                nxt_cnt;
    logic                      sel_ff;
    logic                      nxt_sel;
    logic                      we_ff;
    logic                      nxt_we;
    logic                      src_ff;
    logic                      nxt_src;
    logic [`PMP_ADDR_W-1:0]    addr_ff;
    logic [`PMP_ADDR_W-1:0]    nxt_addr;
    logic [15:0]               wdata_ff;
    logic [15:0]               nxt_wdata;
    logic [15:0]               data_ff;
    logic [15:0]               nxt_data;
    logic [15:0]               rdata_ff;
    logic [15:0]               nxt_rdata;

    // slave state
    pmp_pkg::pmp_byte_t        tx_buf_ff [`PMP_SLV_DEPTH];
    pmp_pkg::pmp_byte_t        rx_buf_ff [`PMP_SLV_DEPTH];
    logic [1:0]                ptr_ff;
    logic                      slv_prev_ff;
    logic                      slv_rx_ff;

    // request selection and window decode
    wire                       gfx_sel  = alt_master_en_in & gfx_req_in;
    wire        [23:0]         req_addr = gfx_sel ? gfx_addr_in : cpu_addr_in;
    wire                       req_we   = gfx_sel ? gfx_we_in : cpu_we_in;
    wire        [15:0]         req_wd   = gfx_sel ? gfx_wdata_in : cpu_wdata_in;
    wire                       hit1     = region_hit(req_addr, cs1_base_in, cs1_mask_in, cs_en_in[0]);
    wire                       hit2     = region_hit(req_addr, cs2_base_in, cs2_mask_in, cs_en_in[1]);
    wire                       req_any  = gfx_sel | cpu_req_in;
    wire                       go       = master_mode_in & req_any & (hit1 | hit2)
                                          & (state_ff == pmp_pkg::st_idle);
    wire        [15:0]         bw_mask  = width_mask(bus_width_in, master_mode_in);
    wire        [3:0]          dwait    = sel_ff ? cs2_data_wait_in : cs1_data_wait_in;
    wire                       ack_ok   = !ack_en_in[sel_ff] | ack_in[sel_ff];
    wire                       done     = (state_ff == pmp_pkg::st_done);
    wire        [1:0]          slv_idx  = !slv_enhanced_in ? `PMP_PTR_RST
                                          : (slv_addr_mode_in ? slv_addr_in : ptr_ff);

    // sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_sel   = sel_ff;
        nxt_we    = we_ff;
        nxt_src   = src_ff;
        nxt_addr  = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_data  = data_ff;
        nxt_rdata = rdata_ff;
        case (state_ff)
            pmp_pkg::st_idle:
            begin
                if (go)
                begin
                    nxt_sel   = !hit1;
                    nxt_we    = req_we;
                    nxt_src   = gfx_sel;
                    nxt_addr  = req_addr[`PMP_ADDR_W-1:0];
                    nxt_wdata = req_wd & bw_mask;
                    nxt_cnt   = {2'h0, addr_wait_in};
                    nxt_data  = mux_mode_in ? req_addr[15:0] : (req_wd & bw_mask);
                    nxt_state = pmp_pkg::st_addr;
                end
            end
            pmp_pkg::st_addr:
            begin
                if (cnt_ff == `PMP_CNT_RST)
                begin
                    nxt_cnt   = dwait;
                    nxt_data  = wdata_ff;
                    nxt_state = pmp_pkg::st_data;
                end
                else
                    nxt_cnt = cnt_ff - 4'h1;
            end
            pmp_pkg::st_data:
            begin
                if (cnt_ff != `PMP_CNT_RST)
                    nxt_cnt = cnt_ff - 4'h1;
                else if (ack_ok)
                begin
                    if (!we_ff)
                        nxt_rdata = data_in & bw_mask;
                    nxt_state = pmp_pkg::st_done;
                end
            end
            pmp_pkg::st_done:
                nxt_state = pmp_pkg::st_idle;
            default:
                nxt_state = pmp_pkg::st_idle;
        endcase
        if (!master_mode_in)
            nxt_data = {8'h00, tx_buf_ff[slv_idx]};
    end

    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= pmp_pkg::st_idle;
            cnt_ff   <= `PMP_CNT_RST;
            sel_ff   <= 1'b0;
            we_ff    <= 1'b0;
            src_ff   <= 1'b0;
            addr_ff  <= `PMP_ADDR_RST;
            wdata_ff <= `PMP_DATA_RST;
            data_ff  <= `PMP_DATA_RST;
            rdata_ff <= `PMP_DATA_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            sel_ff   <= nxt_sel;
            we_ff    <= nxt_we;
            src_ff   <= nxt_src;
            addr_ff  <= nxt_addr;
            wdata_ff <= nxt_wdata;
            data_ff  <= nxt_data;
            rdata_ff <= nxt_rdata;
        end
    end

    // requester handshake
    wire                       cpu_hit = region_hit(cpu_addr_in, cs1_base_in, cs1_mask_in, cs_en_in[0])
                                       | region_hit(cpu_addr_in, cs2_base_in, cs2_mask_in, cs_en_in[1]);
    wire                       gfx_hit = region_hit(gfx_addr_in, cs1_base_in, cs1_mask_in, cs_en_in[0])
                                       | region_hit(gfx_addr_in, cs2_base_in, cs2_mask_in, cs_en_in[1]);

    assign cpu_hit_out   = cpu_hit;
    assign cpu_done_out  = done & !src_ff;
    assign gfx_done_out  = done & src_ff;
    assign cpu_stall_out = master_mode_in & cpu_req_in & cpu_hit & !cpu_done_out;
    assign gfx_stall_out = master_mode_in & alt_master_en_in & gfx_req_in & gfx_hit
                           & !gfx_done_out;
    assign rd_data_out   = rdata_ff;

    // control pins, levels before polarity
    wire                       in_cycle = master_mode_in
                                          & ((state_ff == pmp_pkg::st_addr) | (state_ff == pmp_pkg::st_data));
    wire                       in_data  = master_mode_in & (state_ff == pmp_pkg::st_data);
    wire                       in_adr   = master_mode_in & (state_ff == pmp_pkg::st_addr);
    wire                       rwen     = strobe_mode_in[sel_ff] == `PMP_STB_RWEN;
    wire                       stb_a    = rwen ? (in_cycle & !we_ff) : (in_data & !we_ff);
    wire                       stb_b    = rwen ? in_data : (in_data & we_ff);
    wire                       inv      = !polarity_in[sel_ff];
    wire                       cs1_act  = in_cycle & !sel_ff;
    wire                       cs2_act  = in_cycle & sel_ff;

    assign cs1_pin_out   = cs1_act ^ !polarity_in[0];
    assign strobe_rd_out = stb_a ^ inv;
    assign strobe_wr_out = stb_b ^ inv;
    assign ale_out       = (in_adr & mux_mode_in) ^ inv;
    wire        [23:0]     lg_pins  = {cs2_act ^ !polarity_in[1], addr_ff};
    assign pad_map_out   = alt_pin_map_select_in ? swap_pins(lg_pins) : lg_pins;
    assign data_out      = data_ff;

    // slave port, 8-bit only
    wire                       slv_on   = !master_mode_in;
    wire                       slv_stb  = slv_cs_in & (slv_rd_in | slv_wr_in);
    wire                       slv_edge = slv_on & slv_stb & !slv_prev_ff;

    assign data_oe_out = slv_on ? (slv_cs_in & slv_rd_in)
                                : ((in_adr & mux_mode_in) | (in_data & we_ff));

    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            ptr_ff      <= `PMP_PTR_RST;
            slv_prev_ff <= 1'b0;
            slv_rx_ff   <= 1'b0;
        end
        else
        begin
            slv_prev_ff <= slv_stb;
            slv_rx_ff   <= slv_edge & slv_wr_in;
            if (slv_edge & slv_enhanced_in)
                ptr_ff <= slv_idx + 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < `PMP_SLV_DEPTH; i++)
            begin
                tx_buf_ff[i] <= `PMP_BYTE_RST;
                rx_buf_ff[i] <= `PMP_BYTE_RST;
            end
        end
        else
        begin
            if (buf_load_in)
                tx_buf_ff[buf_load_idx_in] <= buf_load_data_in;
            if (slv_edge & slv_wr_in)
                rx_buf_ff[slv_idx] <= data_in[7:0];
        end
    end

    assign buf_rx_out  = {rx_buf_ff[3], rx_buf_ff[2], rx_buf_ff[1], rx_buf_ff[0]};
    assign slv_rx_out  = slv_rx_ff;
    assign slv_ptr_out = ptr_ff;

endmodule

/* File: hw/pmp_regs.svh */
`ifndef PMP_REGS_SVH
`define PMP_REGS_SVH

// address and page widths
`define PMP_ADDR_W    23
`define PMP_PAGE_W    9
`define PMP_PAGE_LSB  15
// data bus width codes
`define PMP_BW_8      2'h0
`define PMP_BW_16     2'h1
`define PMP_BW_4      2'h2
`define PMP_MASK_4    16'h000f
`define PMP_MASK_8    16'h00ff
`define PMP_MASK_16   16'hffff
// strobe mode codes, one bit per chip select
`define PMP_STB_SPLIT 1'h0
`define PMP_STB_RWEN  1'h1
// slave buffer
`define PMP_SLV_DEPTH 4
// reset values
`define PMP_CNT_RST   4'h0
`define PMP_DATA_RST  16'h0000
`define PMP_ADDR_RST  23'h000000
`define PMP_BYTE_RST  8'h00
`define PMP_PTR_RST   2'h0

`endif

/* File: hw/pmp_pkg.sv */
package pmp_pkg;

    // master cycle sequencer, one-hot
    typedef enum logic [3:0]
    {
        st_idle = 4'h1,
        st_addr = 4'h2,
        st_data = 4'h4,
        st_done = 4'h8
    } pmp_state_t;

    typedef logic [7:0] pmp_byte_t;

endpackage

/* File: testbench/pmp_top_assertions.sv */
`timescale 1ns/1ns
`include "pmp_regs.svh"
module pmp_top_assertions
(
    // clock and reset
    input wire logic        clk_in,
    input wire logic        rstn_in,
    // watched ports
    input wire logic        master_mode_in,
    input wire logic [1:0]  bus_width_in,
    input wire logic        mux_mode_in,
    input wire logic        cpu_req_in,
    input wire logic        cpu_we_in,
    input wire logic        cpu_hit_out,
    input wire logic        cpu_stall_out,
    input wire logic        cpu_done_out,
    input wire logic        gfx_req_in,
    input wire logic        gfx_we_in,
    input wire logic        gfx_done_out,
    input wire logic [15:0] rd_data_out,
    input wire logic        data_oe_out,
    input wire logic        slv_enhanced_in,
    input wire logic        slv_addr_mode_in,
    input wire logic        slv_cs_in,
    input wire logic        slv_rd_in,
    input wire logic        slv_wr_in,
    input wire logic        slv_rx_out,
    input wire logic [1:0]  slv_ptr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic slv_go;
    assign slv_go = slv_cs_in & (slv_rd_in | slv_wr_in) & !master_mode_in;

    stall_on_req_a: assert property (cpu_done_out |-> $past(cpu_stall_out))
        else $error("done without a stalled request");
    miss_no_stall_a: assert property (!cpu_hit_out |-> !cpu_stall_out && !cpu_done_out)
        else $error("stall or done without a hit");
    done_single_a: assert property (cpu_done_out |=> !cpu_done_out)
        else $error("done longer than one cycle");
    min_cycle_a: assert property ($rose(cpu_stall_out) |-> !cpu_done_out [*3])
        else $error("cycle shorter than three clocks");
    read_oe_low_a: assert property (cpu_stall_out && !cpu_we_in && !mux_mode_in && !gfx_req_in |-> !data_oe_out)
        else $error("data driven during read");
    width8_mask_a: assert property (cpu_done_out && !cpu_we_in && bus_width_in == `PMP_BW_8 |-> rd_data_out[15:8] == 8'h00)
        else $error("8-bit read not masked");
    width4_mask_a: assert property (gfx_done_out && !gfx_we_in && bus_width_in == `PMP_BW_4 |-> rd_data_out[15:4] == 12'h000)
        else $error("4-bit read not masked");
    slave_rx_a: assert property ($rose(slv_go) && slv_wr_in |=> slv_rx_out ##1 !slv_rx_out)
        else $error("slave write pulse wrong");
    ptr_step_a: assert property ($rose(slv_go) && slv_enhanced_in && !slv_addr_mode_in |=>
        slv_ptr_out == $past(slv_ptr_out) + 2'h1)
        else $error("slave pointer did not advance");
endmodule

bind pmp_top pmp_top_assertions chk (.clk_in, .rstn_in, .master_mode_in, .bus_width_in, .mux_mode_in,
    .cpu_req_in, .cpu_we_in, .cpu_hit_out, .cpu_stall_out, .cpu_done_out, .gfx_req_in, .gfx_we_in,
    .gfx_done_out, .rd_data_out, .data_oe_out, .slv_enhanced_in, .slv_addr_mode_in, .slv_cs_in,
    .slv_rd_in, .slv_wr_in, .slv_rx_out, .slv_ptr_out);

/* File: testbench/pmp_ext_model.sv */
`timescale 1ns/1ns
module pmp_ext_model
(
    // bus pins from the port
    input  wire logic        clk_in,
    input  wire logic        cs1_in,
    input  wire logic        cs2_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic [22:0] pads_in,
    input  wire logic [15:0] dout_in,
    // setup seen by the far side
    input  wire logic [1:0]  pol_in,
    input  wire logic [1:0]  rwen_in,
    input  wire logic [15:0] rword_in,
    input  wire logic [3:0]  ack_dly_in,
    // answers
    output logic [15:0]      din_out,
    output logic [1:0]       ack_out,
    output logic [22:0]      addr_out,
    output logic [15:0]      wdata_out
);
    logic       sel, cs_act, rd_act, wr_act, rd_on, wr_on;
    logic [3:0] cnt_ff, nxt_cnt;
    assign sel     = (cs2_in == pol_in[1]);
    assign cs_act  = sel | (cs1_in == pol_in[0]);
    assign rd_act  = (rd_in == pol_in[sel]);
    assign wr_act  = (wr_in == pol_in[sel]);
    assign rd_on   = cs_act & (rwen_in[sel] ? rd_act & wr_act : rd_act);
    assign wr_on   = cs_act & (rwen_in[sel] ? !rd_act & wr_act : wr_act);
    assign nxt_cnt = !(rd_on | wr_on) ? 4'h0 : cnt_ff + {3'h0, cnt_ff != 4'hf};
    // lines show the inverse when not read
    assign din_out = rd_on ? rword_in : ~rword_in;
    assign ack_out = {sel, !sel} & {2{(rd_on | wr_on) && cnt_ff >= ack_dly_in}};
    always_ff @(posedge clk_in)
    begin
        cnt_ff <= nxt_cnt;
        if (cs_act)
            addr_out <= pads_in;
        if (wr_on)
            wdata_out <= dout_in;
    end
endmodule

/* File: testbench/pmp_top_bench.sv */
`timescale 1ns/1ns
`include "pmp_regs.svh"
module pmp_top_bench;
    logic        clk_in, rstn_in, master_mode_in, mux_mode_in, alt_pin_map_select_in, alt_master_en_in;
    logic [1:0]  bus_width_in, addr_wait_in, cs_en_in, strobe_mode_in, polarity_in, ack_en_in, ack_in;
    logic [8:0]  cs1_base_in, cs1_mask_in, cs2_base_in, cs2_mask_in;
    logic [3:0]  cs1_data_wait_in, cs2_data_wait_in, ack_dly;
    logic        cpu_req_in, cpu_we_in, cpu_hit_out, cpu_stall_out, cpu_done_out;
    logic        gfx_req_in, gfx_we_in, gfx_stall_out, gfx_done_out;
    logic [23:0] cpu_addr_in, gfx_addr_in, pad_map_out;
    logic [15:0] cpu_wdata_in, gfx_wdata_in, rd_data_out, data_out, data_in, mdl_d, slv_d, rword, cap_wdata;
    logic        slv_enhanced_in, slv_addr_mode_in, slv_cs_in, slv_rd_in, slv_wr_in, slv_rx_out;
    logic [1:0]  slv_addr_in, buf_load_idx_in, slv_ptr_out;
    logic        buf_load_in, cs1_pin_out, strobe_rd_out, strobe_wr_out, ale_out, data_oe_out, cs2_pin;
    logic [7:0]  buf_load_data_in;
    logic [31:0] buf_rx_out;
    logic [22:0] cap_addr;
    int          miscompares, checks, n;

    assign data_in = master_mode_in ? mdl_d : slv_d;
    assign cs2_pin = alt_pin_map_select_in ? pad_map_out[22] : pad_map_out[23];

    pmp_top uut (.clk_in, .rstn_in, .master_mode_in, .bus_width_in, .mux_mode_in, .alt_pin_map_select_in,
        .alt_master_en_in, .addr_wait_in, .cs_en_in, .cs1_base_in, .cs1_mask_in, .cs2_base_in, .cs2_mask_in,
        .cs1_data_wait_in, .cs2_data_wait_in, .strobe_mode_in, .polarity_in, .ack_en_in, .cpu_req_in,
        .cpu_we_in, .cpu_addr_in, .cpu_wdata_in, .cpu_hit_out, .cpu_stall_out, .cpu_done_out, .gfx_req_in,
        .gfx_we_in, .gfx_addr_in, .gfx_wdata_in, .gfx_stall_out, .gfx_done_out, .rd_data_out,
        .slv_enhanced_in, .slv_addr_mode_in, .slv_cs_in, .slv_rd_in, .slv_wr_in, .slv_addr_in, .buf_load_in,
        .buf_load_idx_in, .buf_load_data_in, .buf_rx_out, .slv_rx_out, .slv_ptr_out, .pad_map_out,
        .cs1_pin_out, .strobe_rd_out, .strobe_wr_out, .ale_out, .data_out, .data_oe_out, .data_in, .ack_in);

    pmp_ext_model far_end (.clk_in, .cs1_in(cs1_pin_out), .cs2_in(cs2_pin), .rd_in(strobe_rd_out),
        .wr_in(strobe_wr_out), .pads_in(pad_map_out[22:0]), .dout_in(data_out), .pol_in(polarity_in),
        .rwen_in(strobe_mode_in), .rword_in(rword), .ack_dly_in(ack_dly), .din_out(mdl_d),
        .ack_out(ack_in), .addr_out(cap_addr), .wdata_out(cap_wdata));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one master transfer, n counts clocks until done
    task automatic access(input logic g, input logic we, input logic [23:0] a, input logic [15:0] wd);
        @(negedge clk_in);
        {cpu_req_in, gfx_req_in, cpu_we_in, gfx_we_in} = {!g, g, we, we};
        {cpu_addr_in, gfx_addr_in, cpu_wdata_in, gfx_wdata_in} = {a, a, wd, wd};
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
            @(negedge clk_in);
        end
        while ((g ? gfx_done_out : cpu_done_out) !== 1'b1 && n < 60);
        {cpu_req_in, gfx_req_in} = 2'h0;
    endtask

    task automatic slv_xfer(input logic wr, input logic [1:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {slv_cs_in, slv_rd_in, slv_wr_in, slv_addr_in, slv_d} = {1'b1, !wr, wr, a, 8'h00, d};
        @(negedge clk_in);
        if (!wr)
            check("slave read", {data_oe_out, data_out[7:0]}, {1'b1, d});
        {slv_cs_in, slv_rd_in, slv_wr_in, slv_d} = {3'h0, ~slv_d};
        @(negedge clk_in);
    endtask

    task automatic read_narrow();
        {addr_wait_in, cs1_data_wait_in} = {2'h1, 4'h2};
        access(1'b0, 1'b0, 24'h008038, 16'h0000);
        check("cycle length", n, 6);
        check("read data", rd_data_out, 16'h00c3);
        check("address pins", cap_addr, 23'h008038);
    endtask

    task automatic remap_pins();
        {addr_wait_in, cs1_data_wait_in, alt_pin_map_select_in} = {2'h0, 4'h0, 1'b1};
        access(1'b0, 1'b0, 24'h008038, 16'h0000);
        check("short cycle", n, 3);
        check("swapped pins", cap_addr, 23'h348000);
        alt_pin_map_select_in = 1'b0;
    endtask

    task automatic write_ack();
        {bus_width_in, strobe_mode_in, polarity_in, ack_en_in} = {`PMP_BW_16, 2'h2, 2'h1, 2'h2};
        {cs2_data_wait_in, ack_dly} = {4'h1, 4'h6};
        access(1'b0, 1'b1, 24'h010002, 16'h1234);
        check("write data", cap_wdata, 16'h1234);
        check("ack stretch", n, 9);
        {bus_width_in, strobe_mode_in, polarity_in, ack_en_in, ack_dly} = {8'h0c, 4'h0};
    endtask

    task automatic mux_read();
        {mux_mode_in, addr_wait_in, alt_master_en_in} = 4'hb;
        fork
            access(1'b1, 1'b0, 24'h008038, 16'h0000);
            begin
                repeat (2) @(negedge clk_in);
                check("mux address", {gfx_stall_out, ale_out, data_oe_out, data_out}, {3'h7, 16'h8038});
            end
        join
        check("mux cycle", n, 4);
        check("mux read data", rd_data_out, 16'h00c3);
        {mux_mode_in, addr_wait_in, alt_master_en_in} = 4'h0;
    endtask

    task automatic gfx_read();
        {alt_master_en_in, bus_width_in} = {1'b1, `PMP_BW_4};
        access(1'b1, 1'b0, 24'h008000, 16'h0000);
        check("gfx read data", rd_data_out, 16'h0003);
        check("gfx cycle", n, 3);
        {alt_master_en_in, bus_width_in} = {1'b0, `PMP_BW_8};
    endtask

    task automatic region_decode();
        logic [23:0] a [4] = '{24'h007fff, 24'h008000, 24'h017fff, 24'h018000};
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk_in);
            cpu_addr_in = a[i];
            #1 check("region hit", cpu_hit_out, i == 1 || i == 2);
        end
        @(negedge clk_in);
        cpu_req_in = 1'b1;
        repeat (4) @(negedge clk_in);
        check("miss stall", {cpu_stall_out, cpu_done_out}, 2'h0);
        {cpu_req_in, cs_en_in, cpu_addr_in} = {1'b0, 2'h2, 24'h008000};
        #1 check("disabled region", cpu_hit_out, 0);
        cs_en_in = 2'h3;
    endtask

    task automatic slave_port();
        {master_mode_in, slv_enhanced_in} = 2'h1;
        for (int k = 1; k < 5; k++)
            slv_xfer(1'b1, 2'h0, 8'(k * 17));
        check("slave buffer", buf_rx_out, 32'h44332211);
        check("slave pointer", slv_ptr_out, 2'h0);
        slv_addr_mode_in = 1'b1;
        slv_xfer(1'b1, 2'h2, 8'h77);
        check("addressed write", buf_rx_out, 32'h44772211);
        {buf_load_in, buf_load_idx_in, buf_load_data_in} = {1'b1, 2'h1, 8'h5a};
        @(negedge clk_in);
        buf_load_in = 1'b0;
        slv_xfer(1'b0, 2'h1, 8'h5a);
        {slv_enhanced_in, slv_addr_mode_in} = 2'h0;
        slv_xfer(1'b1, 2'h3, 8'h99);
        check("legacy write", {buf_rx_out, slv_ptr_out}, {32'h44772299, 2'h2});
        master_mode_in = 1'b1;
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    initial
    begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        {rstn_in, cpu_req_in, gfx_req_in, cpu_we_in, gfx_we_in, buf_load_in} = 6'h00;
        {slv_cs_in, slv_rd_in, slv_wr_in, slv_enhanced_in, slv_addr_mode_in} = 5'h00;
        {master_mode_in, mux_mode_in, alt_pin_map_select_in, alt_master_en_in} = 4'h8;
        {cpu_addr_in, gfx_addr_in, cpu_wdata_in, gfx_wdata_in} = '0;
        {slv_addr_in, buf_load_idx_in, buf_load_data_in, slv_d} = '0;
        {cs_en_in, cs1_base_in, cs1_mask_in, cs2_base_in, cs2_mask_in} = {2'h3, 9'h001, 9'h1ff, 9'h002, 9'h1ff};
        {bus_width_in, addr_wait_in, strobe_mode_in, polarity_in, ack_en_in} = 10'h00c;
        {cs1_data_wait_in, cs2_data_wait_in, ack_dly, rword} = {12'h000, 16'ha5c3};
        repeat (8) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        read_narrow();
        remap_pins();
        write_ack();
        gfx_read();
        mux_read();
        region_decode();
        slave_port();
        tally_and_finish();
    end
endmodule
